/* File: bench/dfc_link_sva.sv */
// link and alarm line checker for the host and converter pair
`timescale 1ns/10ps
`default_nettype none
module dfc_link_sva #(
	parameter int HALF = 8
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic sclk,
	input wire logic sdin,
	input wire logic sdo,
	input wire logic latch_n,
	input wire logic clear,
	input wire logic clr_sel_pin,
	input wire logic fault_o,
	input wire logic fault_oe,
	input wire logic fault_n
);
	// ----------------------------------------
	// helper counters
	// ----------------------------------------
	logic [7:0] hi_r, hi_nxt, rise_r, rise_nxt;
	logic sclk_r;

	always_comb begin
		hi_nxt = sclk ? hi_r + 8'h01 : 8'h00;
		// rises are counted only inside a frame, so a stray edge shows up as a bad count
		rise_nxt = latch_n ? 8'h00 : rise_r + {7'h00, sclk & ~sclk_r};
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			hi_r <= 8'h00;
			rise_r <= 8'h00;
			sclk_r <= 1'b0;
		end else begin
			hi_r <= hi_nxt;
			rise_r <= rise_nxt;
			sclk_r <= sclk;
		end
	end

	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	a_alarm_pull: assert property (fault_oe |-> !fault_n)
		else $error("alarm line not low while pulled");
	a_alarm_free: assert property (!fault_oe |-> fault_n)
		else $error("alarm line low while released");
	a_drain_only: assert property (fault_oe |-> fault_o == 1'b0)
		else $error("alarm pin drives high");
	a_sclk_idle: assert property (latch_n |-> !sclk)
		else $error("serial clock high outside a frame");
	a_sdin_hold: assert property ($past(sclk) && sclk |-> $stable(sdin))
		else $error("serial data moved while clock high");
	a_high_len: assert property ($fell(sclk) |-> hi_r == HALF)
		else $error("serial clock high phase has wrong length");
	a_bit_count: assert property ($rose(latch_n) |-> rise_r == 8'd24 || rise_r == 8'd0)
		else $error("frame ended with a partial bit count");
	a_latch_lead: assert property ($fell(latch_n) |-> !sclk ##1 !sclk)
		else $error("serial clock rose too soon after load strobe fell");
	a_frame_ends: assert property ($fell(latch_n) |-> ##[1:1000] $rose(latch_n))
		else $error("load strobe stuck low");
	a_pins_quiet: assert property ($changed(clear) || $changed(clr_sel_pin) |-> latch_n)
		else $error("clear pins moved inside a frame");
	a_sdo_rest: assert property (latch_n [*8] |-> !sdo)
		else $error("readback line busy outside a frame");
endmodule
`default_nettype wire

/* File: bench/test_dac_fault_and_clear_control.sv */
// self-checking bench for the host and converter pair
`timescale 1ns/10ps
`default_nettype none
`include "dfc_cfg.svh"
module test_dac_fault_and_clear_control;
	localparam int HALF = 4;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic headroom_low = 1'b0, over_temp = 1'b0, modem_pin = 1'b0;
	logic [4:0] awaddr = 5'h00, araddr = 5'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, rd_val;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, resp;
	logic [15:0] dac_code;
	logic [2:0] range_code;
	logic rx_bit, rp_bit, oen, modem_out, compl, therm, cleared;
	logic slew_en;
	logic [3:0] slew_clock;
	logic [2:0] slew_step;
	int err_count = 0, checked = 0;

	dfc_link_if lk ();
	dfc_dev i_dfc_dev (.sys_clk(sys_clk), .reset_n(reset_n), .lk(lk.dev),
		.headroom_low(headroom_low), .over_temp(over_temp), .modem_inject_pin(modem_pin),
		.dac_code(dac_code), .range_code(range_code), .range_extend_bit(rx_bit),
		.ext_resistor_pick(rp_bit), .output_drive_on(oen), .slew_en(slew_en),
		.slew_clock(slew_clock), .slew_step(slew_step), .modem_out(modem_out),
		.loop_compliance_flag(compl),
		.thermal_flag(therm), .cleared(cleared));
	dfc_host #(.HALF(HALF)) i_dfc_host (.sys_clk(sys_clk), .reset_n(reset_n), .lk(lk.host),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	dfc_link_sva #(.HALF(HALF)) i_dfc_link_sva (.sys_clk(sys_clk), .reset_n(reset_n),
		.sclk(lk.sclk), .sdin(lk.sdin), .sdo(lk.sdo), .latch_n(lk.latch_n),
		.clear(lk.clear), .clr_sel_pin(lk.clr_sel_pin), .fault_o(lk.fault_o),
		.fault_oe(lk.fault_oe), .fault_n(lk.fault_n));

	initial begin
		forever #10 sys_clk = ~sys_clk;
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic stop_test();
		if (err_count == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// waits are unbounded here; the watchdog cuts a hang short
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic done;
		done = 1'b0;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(posedge sys_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) begin
				resp = bresp;
				bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask

	task automatic rd(input logic [4:0] a);
		logic done;
		done = 1'b0;
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(posedge sys_clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) begin
				rd_val = rdata;
				resp = rresp;
				rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask

	task automatic wcode(input logic [15:0] e);
		for (int n = 0; n < 1000 && dac_code !== e; n++) @(posedge sys_clk);
		chk({16'h0, dac_code}, {16'h0, e});
	endtask

	// the converter commits a few cycles after the link goes idle, through its synchronisers
	task automatic idle();
		rd(`DFC_OFS_STATUS);
		while (rd_val[0] !== 1'b0) rd(`DFC_OFS_STATUS);
		repeat (8) @(posedge sys_clk);
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		chk({16'h0, dac_code}, 32'h0);
		chk({31'h0, lk.fault_n}, 32'h1);
		wr(`DFC_OFS_DATA, 32'h1234);
		wcode(16'h1234);
		wr(`DFC_OFS_CTRL, 32'h9001);
		wcode(16'h8000);
		chk({28'h0, oen, range_code}, 32'h9);
		for (int r = 0; r < 4; r++) begin
			for (int s = 0; s < 2; s++) begin
				wr(`DFC_OFS_CTRL, 32'h1000 | r);
				wr(`DFC_OFS_DATA, 32'h2222);
				wcode(16'h2222);
				wr(`DFC_OFS_PINS, {30'h0, s[0], 1'b1});
				wcode((r[1] ^ s[0]) ? 16'h8000 : 16'h0000);
				chk({31'h0, cleared}, 32'h1);
				wr(`DFC_OFS_PINS, 32'h0);
			end
		end
		wr(`DFC_OFS_DATA, 32'h1234);
		wcode(16'h1234);
		wr(`DFC_OFS_PINS, 32'h1);
		wcode(16'h8000);
		wr(`DFC_OFS_DATA, 32'h5555);
		chk({30'h0, resp}, {30'h0, `DFC_RESP_OKAY});
		rd(`DFC_OFS_STATUS);
		chk({31'h0, rd_val[2]}, 32'h1);
		chk({16'h0, dac_code}, 32'h8000);
		wr(`DFC_OFS_PINS, 32'h0);
		idle();
		chk({16'h0, dac_code}, 32'h8000);
		wr(`DFC_OFS_ACTION, 32'h1);
		wcode(16'h1234);
		chk({31'h0, cleared}, 32'h0);
		wr(`DFC_OFS_CTRL, 32'h1000);
		wcode(16'h0000);
		wr(`DFC_OFS_DATA, 32'h4444);
		wcode(16'h4444);
		wr(`DFC_OFS_CTRL, 32'h0002);
		wcode(16'h8000);
		wr(`DFC_OFS_CTRL, 32'h7005);
		modem_pin <= 1'b1;
		idle();
		chk({29'h0, rx_bit, rp_bit, modem_out}, 32'h7);
		wr(`DFC_OFS_DATA, 32'h7777);
		wcode(16'h7777);
		wr(`DFC_OFS_PINS, 32'h1);
		wcode(16'h0000);
		wr(`DFC_OFS_PINS, 32'h4);
		wr(`DFC_OFS_CTRL, 32'h6ba5);
		idle();
		chk({31'h0, modem_out}, 32'h0);
		chk({24'h0, slew_clock, slew_step, slew_en}, 32'hbb);
		rd(`DFC_OFS_CTRL);
		chk(rd_val, 32'h6bb5);
		headroom_low <= 1'b1;
		wr(`DFC_OFS_DATA, 32'h0100);
		wcode(16'h0100);
		idle();
		chk({29'h0, compl, therm, lk.fault_n}, 32'h4);
		rd(`DFC_OFS_STATUS);
		chk(rd_val, 32'h00040002);
		headroom_low <= 1'b0;
		over_temp <= 1'b1;
		wr(`DFC_OFS_DATA, 32'h0200);
		wcode(16'h0200);
		idle();
		chk({29'h0, compl, therm, lk.fault_n}, 32'h2);
		rd(`DFC_OFS_STATUS);
		chk(rd_val, 32'h00010002);
		over_temp <= 1'b0;
		idle();
		chk({29'h0, compl, therm, lk.fault_n}, 32'h1);
		wr(5'h14, 32'h1);
		chk({30'h0, resp}, {30'h0, `DFC_RESP_SLVERR});
		rd(5'h14);
		chk({30'h0, resp}, {30'h0, `DFC_RESP_SLVERR});
		wr(`DFC_OFS_ACTION, 32'h2);
		wcode(16'h0000);
		chk({28'h0, oen, range_code}, 32'h0);
		stop_test();
	end

	initial begin
		repeat (60000) @(posedge sys_clk);
		err_count++;
		$display("unexpected at %0t: watchdog expired", $time);
		stop_test();
	end
endmodule
`default_nettype wire

/* File: core/dfc_cfg.svh */
// constants for the converter fault and clear control pair
`ifndef DFC_CFG_SVH
`define DFC_CFG_SVH

`define DFC_ADDR_DATA 8'h01
`define DFC_ADDR_CTRL 8'h55
`define DFC_ADDR_RESET 8'h56
`define DFC_ZMSEL_BIT 15
`define DFC_EXTEND_BIT 14
`define DFC_EXT_RESISTOR_PICK_BIT 13
`define DFC_OUTPUT_DRIVE_ON_BIT 12
`define DFC_SRCLK_MSB 11
`define DFC_SRCLK_LSB 8
`define DFC_SRSTEP_MSB 7
`define DFC_SRSTEP_LSB 5
`define DFC_SREN_BIT 4
`define DFC_RANGE_MSB 2
`define DFC_RANGE_LSB 0
`define DFC_RST_BIT 0
`define DFC_ST_COMPL_BIT 2
`define DFC_ST_THERM_BIT 0
`define DFC_FRAME_BITS 5'd24
`define DFC_CODE_MID 16'h8000
`define DFC_CODE_ZERO 16'h0000
`define DFC_CTRL_RST 16'h0000

`define DFC_OFS_CTRL 5'h00
`define DFC_OFS_DATA 5'h04
`define DFC_OFS_PINS 5'h08
`define DFC_OFS_ACTION 5'h0c
`define DFC_OFS_STATUS 5'h10
`define DFC_PIN_CLR_BIT 0
`define DFC_PIN_SEL_BIT 1
`define DFC_PIN_HART_BIT 2
`define DFC_ACT_RESTORE_BIT 0
`define DFC_ACT_DEVRST_BIT 1
`define DFC_RESP_OKAY 2'b00
`define DFC_RESP_SLVERR 2'b10

`define DFC_HALF_CYC 8

`endif

/* File: core/dfc_dev.sv */
// converter end: serial decode, clear handling, fault alarm
`timescale 1ns/10ps
`default_nettype none
`include "dfc_cfg.svh"
module dfc_dev
	import dfc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	dfc_link_if.dev lk,
	input wire logic headroom_low,
	input wire logic over_temp,
	input wire logic modem_inject_pin,
	output logic [15:0] dac_code,
	output logic [2:0] range_code,
	output logic range_extend_bit,
	output logic ext_resistor_pick,
	output logic output_drive_on,
	output logic slew_en,
	output logic [3:0] slew_clock,
	output logic [2:0] slew_step,
	output logic modem_out,
	output logic loop_compliance_flag,
	output logic thermal_flag,
	output logic cleared
);
	// ---------------------------------------------
	// pin synchronisers
	// ---------------------------------------------
	logic [7:0] pins_s;
	logic sclk_s, sdin_s, latch_s, clear_s, sel_pin_s, room_s, hot_s, modem_s;
	logic latch_low_s;

	// the strobe idles high, so it is synchronised inverted: a zero reset then
	// matches its idle level and no false strobe edge follows reset
	dfc_sync #(.W(8)) u_sync (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.d({lk.sclk, lk.sdin, ~lk.latch_n, lk.clear, lk.clr_sel_pin,
			headroom_low, over_temp, modem_inject_pin}),
		.q(pins_s)
	);
	assign {sclk_s, sdin_s, latch_low_s, clear_s, sel_pin_s, room_s, hot_s, modem_s} = pins_s;
	assign latch_s = ~latch_low_s;

	// ---------------------------------------------
	// state
	// ---------------------------------------------
	logic sclk_q_r, sclk_q_nxt;
	logic latch_q_r, latch_q_nxt;
	logic [4:0] bitcnt_r, bitcnt_nxt;
	dfc_frame_t sreg_r, sreg_nxt;
	dfc_frame_t sdo_r, sdo_nxt;
	logic [15:0] ctrl_r, ctrl_nxt;
	logic [15:0] data_r, data_nxt;
	logic [15:0] out_r, out_nxt;
	logic clr_r, clr_nxt;
	logic compl_r, compl_nxt;
	logic therm_r, therm_nxt;
	logic fault_r, fault_nxt;
	logic modem_r, modem_nxt;

	logic sel_eff;
	logic [15:0] word;
	logic [7:0] addr;
	logic [15:0] status;

	assign word = sreg_r[15:0];
	assign addr = sreg_r[23:16];

	always_comb begin
		sclk_q_nxt = sclk_s;
		latch_q_nxt = latch_s;
		bitcnt_nxt = bitcnt_r;
		sreg_nxt = sreg_r;
		sdo_nxt = sdo_r;
		ctrl_nxt = ctrl_r;
		data_nxt = data_r;
		out_nxt = out_r;
		clr_nxt = clr_r;
		// flags track their condition each cycle, nothing latches them
		compl_nxt = room_s;
		therm_nxt = hot_s;
		fault_nxt = compl_r | therm_r;
		modem_nxt = modem_s & ctrl_r[`DFC_OUTPUT_DRIVE_ON_BIT] & ctrl_r[`DFC_RANGE_MSB];
		sel_eff = sel_pin_s | ctrl_r[`DFC_ZMSEL_BIT];
		status = 16'h0000;
		status[`DFC_ST_COMPL_BIT] = compl_r;
		status[`DFC_ST_THERM_BIT] = therm_r;

		if (sclk_s && !sclk_q_r && bitcnt_r < `DFC_FRAME_BITS) begin
			sreg_nxt = {sreg_r[22:0], sdin_s};
			bitcnt_nxt = bitcnt_r + 5'd1;
		end
		if (!sclk_s && sclk_q_r) begin
			sdo_nxt = {sdo_r[22:0], 1'b0};
		end
		if (!latch_s && latch_q_r) begin
			bitcnt_nxt = 5'd0;
			sdo_nxt = {8'h00, status};
		end

		if (latch_s && !latch_q_r) begin
			if (bitcnt_r == 5'd0) begin
				// empty strobe brings back the value held before the clear
				if (!clear_s) begin
					out_nxt = data_r;
					clr_nxt = 1'b0;
				end
			end else if (bitcnt_r == `DFC_FRAME_BITS) begin
				case (addr)
					`DFC_ADDR_DATA: begin
						if (!clear_s) begin
							data_nxt = word;
							out_nxt = word;
							clr_nxt = 1'b0;
						end
					end
					`DFC_ADDR_CTRL: begin
						ctrl_nxt = word;
						if (word[`DFC_OUTPUT_DRIVE_ON_BIT] && !ctrl_r[`DFC_OUTPUT_DRIVE_ON_BIT]) begin
							out_nxt = dfc_default(word[2:0], sel_pin_s | word[`DFC_ZMSEL_BIT]);
						end else if (!word[`DFC_RANGE_MSB] && word[2:0] != ctrl_r[2:0]) begin
							out_nxt = dfc_default(word[2:0], sel_pin_s | word[`DFC_ZMSEL_BIT]);
						end
					end
					`DFC_ADDR_RESET: begin
						if (word[`DFC_RST_BIT]) begin
							ctrl_nxt = `DFC_CTRL_RST;
							data_nxt = `DFC_CODE_ZERO;
							out_nxt = `DFC_CODE_ZERO;
							clr_nxt = 1'b0;
						end
					end
					default: begin
					end
				endcase
			end
		end

		// clear overrides any output code update in the same cycle
		if (clear_s) begin
			out_nxt = dfc_default(ctrl_r[2:0], sel_eff);
			clr_nxt = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sclk_q_r <= 1'b0;
			latch_q_r <= 1'b1;
			bitcnt_r <= 5'd0;
			sreg_r <= '0;
			sdo_r <= '0;
			ctrl_r <= `DFC_CTRL_RST;
			data_r <= `DFC_CODE_ZERO;
			out_r <= `DFC_CODE_ZERO;
			clr_r <= 1'b0;
			compl_r <= 1'b0;
			therm_r <= 1'b0;
			fault_r <= 1'b0;
			modem_r <= 1'b0;
		end else begin
			sclk_q_r <= sclk_q_nxt;
			latch_q_r <= latch_q_nxt;
			bitcnt_r <= bitcnt_nxt;
			sreg_r <= sreg_nxt;
			sdo_r <= sdo_nxt;
			ctrl_r <= ctrl_nxt;
			data_r <= data_nxt;
			out_r <= out_nxt;
			clr_r <= clr_nxt;
			compl_r <= compl_nxt;
			therm_r <= therm_nxt;
			fault_r <= fault_nxt;
			modem_r <= modem_nxt;
		end
	end

	// ---------------------------------------------
	// outputs
	// ---------------------------------------------
	assign lk.sdo = sdo_r[23];
	assign lk.fault_o = 1'b0;
	assign lk.fault_oe = fault_r;
	assign dac_code = out_r;
	assign range_code = ctrl_r[`DFC_RANGE_MSB:`DFC_RANGE_LSB];
	assign range_extend_bit = ctrl_r[`DFC_EXTEND_BIT];
	assign ext_resistor_pick = ctrl_r[`DFC_EXT_RESISTOR_PICK_BIT];
	assign output_drive_on = ctrl_r[`DFC_OUTPUT_DRIVE_ON_BIT];
	assign slew_en = ctrl_r[`DFC_SREN_BIT];
	assign slew_clock = ctrl_r[`DFC_SRCLK_MSB:`DFC_SRCLK_LSB];
	assign slew_step = ctrl_r[`DFC_SRSTEP_MSB:`DFC_SRSTEP_LSB];
	assign modem_out = modem_r;
	assign loop_compliance_flag = compl_r;
	assign thermal_flag = therm_r;
	assign cleared = clr_r;
endmodule
`default_nettype wire

/* File: core/dfc_host.sv */
// host end: axi4-lite registers driving the serial link and clear pins
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "dfc_cfg.svh"
module dfc_host
	import dfc_pkg::*;
#(
	parameter int HALF = `DFC_HALF_CYC
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	dfc_link_if.host lk,
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic [1:0] in_s;
	logic sdo_s, fault_s;

	// alarm synchronised as active high so the reset value reads as released
	dfc_sync #(.W(2)) u_sync (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.d({lk.sdo, ~lk.fault_n}),
		.q(in_s)
	);
	assign {sdo_s, fault_s} = in_s;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) m[i*8 +: 8] = nw[i*8 +: 8];
		end
		return m;
	endfunction

	dfc_hstate_e st_r, st_nxt;
	logic [7:0] cnt_r, cnt_nxt;
	logic [4:0] nb_r, nb_nxt;
	logic full_r, full_nxt;
	dfc_frame_t sh_r, sh_nxt, rx_r, rx_nxt, pend_r, pend_nxt;
	logic pend_v_r, pend_v_nxt;
	logic sclk_r, sclk_nxt, sdin_r, sdin_nxt, latch_r, latch_nxt;
	logic [15:0] ctrl_r, ctrl_nxt, data_r, data_nxt, stat_r, stat_nxt;
	logic [2:0] pins_r, pins_nxt;
	logic rej_r, rej_nxt;
	logic aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
	logic [4:0] awa_r, awa_nxt;
	logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
	logic [3:0] ws_r, ws_nxt;
	logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
	logic [31:0] m;
	logic [15:0] cw;

	assign s_axi_awready = !aw_r && !bv_r;
	assign s_axi_wready = !w_r && !bv_r;
	assign s_axi_arready = !rv_r;

	always_comb begin
		st_nxt = st_r; cnt_nxt = cnt_r; nb_nxt = nb_r; full_nxt = full_r;
		sh_nxt = sh_r; rx_nxt = rx_r; pend_nxt = pend_r; pend_v_nxt = pend_v_r;
		sclk_nxt = sclk_r; sdin_nxt = sdin_r; latch_nxt = latch_r;
		ctrl_nxt = ctrl_r; data_nxt = data_r; stat_nxt = stat_r; pins_nxt = pins_r;
		rej_nxt = rej_r; aw_nxt = aw_r; w_nxt = w_r; bv_nxt = bv_r; rv_nxt = rv_r;
		awa_nxt = awa_r; wd_nxt = wd_r; ws_nxt = ws_r; rd_nxt = rd_r;
		br_nxt = br_r; rr_nxt = rr_r;
		m = 32'h0000_0000;
		cw = 16'h0000;

		// ---------------------------------------------
		// serial engine
		// ---------------------------------------------
		if (cnt_r != 8'd0) begin
			cnt_nxt = cnt_r - 8'd1;
		end else begin
			case (st_r)
				H_IDLE: begin
				end
				H_LOAD: begin
					cnt_nxt = 8'(HALF - 1);
					if (nb_r == 5'd0) begin
						st_nxt = H_END;
						latch_nxt = 1'b1;
					end else begin
						st_nxt = H_LOW;
						sdin_nxt = sh_r[23];
					end
				end
				H_LOW: begin
					st_nxt = H_HIGH;
					sclk_nxt = 1'b1;
					cnt_nxt = 8'(HALF - 1);
				end
				H_HIGH: begin
					rx_nxt = {rx_r[22:0], sdo_s};
					sh_nxt = {sh_r[22:0], 1'b0};
					nb_nxt = nb_r - 5'd1;
					sclk_nxt = 1'b0;
					cnt_nxt = 8'(HALF - 1);
					if (nb_r == 5'd1) begin
						st_nxt = H_END;
						latch_nxt = 1'b1;
					end else begin
						st_nxt = H_LOW;
						sdin_nxt = sh_r[22];
					end
				end
				H_END: begin
					if (full_r) stat_nxt = rx_r[15:0];
					if (pend_v_r) begin
						// second half of a split control update
						pend_v_nxt = 1'b0;
						sh_nxt = pend_r;
						nb_nxt = `DFC_FRAME_BITS;
						full_nxt = 1'b1;
						st_nxt = H_LOAD;
						latch_nxt = 1'b0;
						cnt_nxt = 8'(HALF - 1);
					end else begin
						st_nxt = H_IDLE;
					end
				end
				default: st_nxt = H_IDLE;
			endcase
		end

		// ---------------------------------------------
		// write channel, carried out only while the link is idle
		// ---------------------------------------------
		if (s_axi_awvalid && s_axi_awready) begin
			aw_nxt = 1'b1;
			awa_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_nxt = 1'b1;
			wd_nxt = s_axi_wdata;
			ws_nxt = s_axi_wstrb;
		end
		if (aw_r && w_r && st_r == H_IDLE) begin
			aw_nxt = 1'b0;
			w_nxt = 1'b0;
			bv_nxt = 1'b1;
			br_nxt = `DFC_RESP_OKAY;
			case ({awa_r[4:2], 2'b00})
				`DFC_OFS_CTRL: begin
					m = merge({16'h0000, ctrl_r}, wd_r, ws_r);
					cw = m[15:0];
					if (pins_r[`DFC_PIN_HART_BIT]) cw[`DFC_SREN_BIT] = 1'b1;
					ctrl_nxt = cw;
					sh_nxt = {`DFC_ADDR_CTRL, cw};
					if (ctrl_r[`DFC_OUTPUT_DRIVE_ON_BIT] && cw[2:0] != ctrl_r[2:0]) begin
						// drop the output first to keep the range switch clean
						sh_nxt = {`DFC_ADDR_CTRL, ctrl_r & ~(16'h0001 << `DFC_OUTPUT_DRIVE_ON_BIT)};
						pend_nxt = {`DFC_ADDR_CTRL, cw};
						pend_v_nxt = 1'b1;
					end
					nb_nxt = `DFC_FRAME_BITS;
					full_nxt = 1'b1;
					st_nxt = H_LOAD;
					latch_nxt = 1'b0;
					cnt_nxt = 8'(HALF - 1);
				end
				`DFC_OFS_DATA: begin
					m = merge({16'h0000, data_r}, wd_r, ws_r);
					if (pins_r[`DFC_PIN_CLR_BIT]) begin
						rej_nxt = 1'b1;
					end else begin
						rej_nxt = 1'b0;
						data_nxt = m[15:0];
						sh_nxt = {`DFC_ADDR_DATA, m[15:0]};
						nb_nxt = `DFC_FRAME_BITS;
						full_nxt = 1'b1;
						st_nxt = H_LOAD;
						latch_nxt = 1'b0;
						cnt_nxt = 8'(HALF - 1);
					end
				end
				`DFC_OFS_PINS: begin
					m = merge({29'h0, pins_r}, wd_r, ws_r);
					pins_nxt = m[2:0];
				end
				`DFC_OFS_ACTION: begin
					if (ws_r[0] && wd_r[`DFC_ACT_DEVRST_BIT]) begin
						sh_nxt = {`DFC_ADDR_RESET, 16'h0001};
						nb_nxt = `DFC_FRAME_BITS;
						full_nxt = 1'b1;
						ctrl_nxt = `DFC_CTRL_RST;
						st_nxt = H_LOAD;
						latch_nxt = 1'b0;
						cnt_nxt = 8'(HALF - 1);
					end else if (ws_r[0] && wd_r[`DFC_ACT_RESTORE_BIT]) begin
						nb_nxt = 5'd0;
						full_nxt = 1'b0;
						st_nxt = H_LOAD;
						latch_nxt = 1'b0;
						cnt_nxt = 8'(HALF - 1);
					end
				end
				`DFC_OFS_STATUS: begin
				end
				default: br_nxt = `DFC_RESP_SLVERR;
			endcase
		end
		if (bv_r && s_axi_bready) bv_nxt = 1'b0;

		// ---------------------------------------------
		// read channel
		// ---------------------------------------------
		if (s_axi_arvalid && s_axi_arready) begin
			rv_nxt = 1'b1;
			rr_nxt = `DFC_RESP_OKAY;
			case ({s_axi_araddr[4:2], 2'b00})
				`DFC_OFS_CTRL: rd_nxt = {16'h0000, ctrl_r};
				`DFC_OFS_DATA: rd_nxt = {16'h0000, data_r};
				`DFC_OFS_PINS: rd_nxt = {29'h0, pins_r};
				`DFC_OFS_ACTION: rd_nxt = 32'h0000_0000;
				`DFC_OFS_STATUS: rd_nxt = {stat_r, 13'h0, rej_r, fault_s, st_r != H_IDLE};
				default: begin
					rd_nxt = 32'h0000_0000;
					rr_nxt = `DFC_RESP_SLVERR;
				end
			endcase
		end else if (rv_r && s_axi_rready) begin
			rv_nxt = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= H_IDLE; cnt_r <= 8'd0; nb_r <= 5'd0; full_r <= 1'b0;
			sh_r <= '0; rx_r <= '0; pend_r <= '0; pend_v_r <= 1'b0;
			sclk_r <= 1'b0; sdin_r <= 1'b0; latch_r <= 1'b1;
			ctrl_r <= `DFC_CTRL_RST; data_r <= `DFC_CODE_ZERO; stat_r <= 16'h0000;
			pins_r <= 3'h0; rej_r <= 1'b0; aw_r <= 1'b0; w_r <= 1'b0;
			bv_r <= 1'b0; rv_r <= 1'b0; awa_r <= 5'h00; wd_r <= 32'h0000_0000;
			ws_r <= 4'h0; rd_r <= 32'h0000_0000; br_r <= 2'b00; rr_r <= 2'b00;
		end else begin
			st_r <= st_nxt; cnt_r <= cnt_nxt; nb_r <= nb_nxt; full_r <= full_nxt;
			sh_r <= sh_nxt; rx_r <= rx_nxt; pend_r <= pend_nxt; pend_v_r <= pend_v_nxt;
			sclk_r <= sclk_nxt; sdin_r <= sdin_nxt; latch_r <= latch_nxt;
			ctrl_r <= ctrl_nxt; data_r <= data_nxt; stat_r <= stat_nxt;
			pins_r <= pins_nxt; rej_r <= rej_nxt; aw_r <= aw_nxt; w_r <= w_nxt;
			bv_r <= bv_nxt; rv_r <= rv_nxt; awa_r <= awa_nxt; wd_r <= wd_nxt;
			ws_r <= ws_nxt; rd_r <= rd_nxt; br_r <= br_nxt; rr_r <= rr_nxt;
		end
	end

	assign lk.sclk = sclk_r;
	assign lk.sdin = sdin_r;
	assign lk.latch_n = latch_r;
	assign lk.clear = pins_r[`DFC_PIN_CLR_BIT];
	assign lk.clr_sel_pin = pins_r[`DFC_PIN_SEL_BIT];
	assign s_axi_bvalid = bv_r;
	assign s_axi_bresp = br_r;
	assign s_axi_rvalid = rv_r;
	assign s_axi_rdata = rd_r;
	assign s_axi_rresp = rr_r;
endmodule
`default_nettype wire

/* File: core/dfc_link_if.sv */
// serial link, clear pins and shared alarm line between host and converter
`timescale 1ns/10ps
`default_nettype none
interface dfc_link_if;
	logic sclk;
	logic sdin;
	logic sdo;
	logic latch_n;
	logic clear;
	logic clr_sel_pin;
	logic fault_o;
	logic fault_oe;
	logic fault_n;

	// open drain with pull-up
	assign fault_n = fault_oe ? fault_o : 1'b1;

	modport dev (input sclk, sdin, latch_n, clear, clr_sel_pin, output sdo, fault_o, fault_oe);
	modport host (output sclk, sdin, latch_n, clear, clr_sel_pin, input sdo, fault_n);
endinterface
`default_nettype wire

/* File: core/dfc_pkg.sv */
// types and the shared default-code decode
`include "dfc_cfg.svh"
package dfc_pkg;
	typedef enum {H_IDLE, H_LOAD, H_LOW, H_HIGH, H_END} dfc_hstate_e;
	typedef logic [23:0] dfc_frame_t;

	// clear and default code for a range and selection
	function automatic logic [15:0] dfc_default(input logic [2:0] rng, input logic sel);
		if (rng[2]) begin
			return `DFC_CODE_ZERO;
		end else if (rng[1]) begin
			return sel ? `DFC_CODE_ZERO : `DFC_CODE_MID;
		end else begin
			return sel ? `DFC_CODE_MID : `DFC_CODE_ZERO;
		end
	endfunction
endpackage

/* File: core/dfc_sync.sv */
// two-stage synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module dfc_sync #(
	parameter int W = 1
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_r <= '0;
			q_r <= '0;
		end else begin
			meta_r <= d;
			q_r <= meta_r;
		end
	end

	assign q = q_r;
endmodule
`default_nettype wire
